// *** hw/vcsft_pkg.sv ***
// Shared constants, types and register map of the video sync, flag and timer block.
package vcsft_pkg;

  // APB register byte offsets.
  localparam logic [7:0] REG_STATUS_OFS = 8'h00;
  localparam logic [7:0] REG_MASK_OFS = 8'h04;
  localparam logic [7:0] REG_STATE_OFS = 8'h08;
  localparam logic [7:0] REG_CONTROL_OFS = 8'h0c;

  // Status and mask bit positions.
  localparam int EV_TIMER_BIT = 0;
  localparam int EV_ACCESS_BIT = 1;
  localparam int EV_WIDTH = 2;

  // Control bit positions and values after reset.
  localparam int CTL_SPEAKER_EN_BIT = 0;
  localparam logic [31:0] CONTROL_RST = 32'h0000_0001;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [1:0] STATUS_RST = 2'h0;

  // Flag line roles.
  localparam int FLAG_COUNT = 8;
  localparam int FLAG_TIMER_EN = 1;
  localparam int FLAG_BELL = 2;
  localparam int FLAG_TICK = 3;
  localparam logic [7:0] FLAGS_RST = 8'h00;

  // Decade counter of field pulses.
  localparam logic [3:0] DECADE_LAST = 4'h9;
  localparam logic [3:0] DECADE_RST = 4'h0;

  // Clock rate and derived counts.
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned TONE_FREQ_HZ = 2000;
  localparam int unsigned TONE_HALF_CYC = CLK_HZ / (2 * TONE_FREQ_HZ);
  localparam int unsigned BELL_TIME_MS = 100;
  localparam int unsigned TICK_TIME_MS = 10;
  localparam int unsigned BELL_CYC = (CLK_HZ / 1000) * BELL_TIME_MS;
  localparam int unsigned TICK_CYC = (CLK_HZ / 1000) * TICK_TIME_MS;
  localparam int CNT_W = 32;

  // Memory access sequencer states.
  typedef enum logic [2:0] {
    ACC_IDLE = 3'b001,
    ACC_GRANT = 3'b010,
    ACC_READY = 3'b100
  } vcsft_acc_t;

  // Pins arriving from the processor bus and video timing.
  typedef struct packed {
    logic display_select_addr_bit;
    logic mem_read_strobe_n;
    logic mem_write_strobe_n;
    logic refresh_pending;
    logic video_read_active;
    logic row_strobe_n;
    logic field_rate_pulse;
    logic flag_latch_load_n;
    logic [3:0] data_low;
    logic timer_irq_clear;
  } vcsft_pins_t;

  localparam vcsft_pins_t PINS_RST = '{
    display_select_addr_bit: 1'b0,
    mem_read_strobe_n: 1'b1,
    mem_write_strobe_n: 1'b1,
    refresh_pending: 1'b0,
    video_read_active: 1'b0,
    row_strobe_n: 1'b1,
    field_rate_pulse: 1'b0,
    flag_latch_load_n: 1'b1,
    data_low: 4'h0,
    timer_irq_clear: 1'b0
  };

  // Outputs toward the processor and the sound stage.
  typedef struct packed {
    logic mem_grant;
    logic cpu_route_en;
    logic ready_n;
    logic timer_irq;
    logic speaker_drive;
    logic [7:0] flag_outputs;
  } vcsft_outs_t;

endpackage

// *** hw/vcsft_sync.sv ***
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module vcsft_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_nxt;

  // A bit only changes once the second and third stages agree.
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q[i];
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1_r <= RST;
      s2_r <= RST;
      s3_r <= RST;
      q <= RST;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q <= q_nxt;
    end
  end

endmodule

// *** hw/vcsft_top.sv ***
// Memory access synchroniser, flag latch, sound gating and field timer with APB registers.
`timescale 1ns/1ps
module vcsft_top #(
  parameter int unsigned TONE_HALF = vcsft_pkg::TONE_HALF_CYC,
  parameter int unsigned BELL_LEN = vcsft_pkg::BELL_CYC,
  parameter int unsigned TICK_LEN = vcsft_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire vcsft_pkg::vcsft_pins_t pins,
  output vcsft_pkg::vcsft_outs_t outs,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  import vcsft_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge detection.

  vcsft_pins_t sp, prev_r;
  logic req, qualify, ras_fall, field_rise;

  vcsft_sync #(
    .W($bits(vcsft_pins_t)),
    .RST(PINS_RST)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .d(pins),
    .q(sp)
  );

  always_ff @(posedge clk)
  begin
    if (srst)
      prev_r <= PINS_RST;
    else
      prev_r <= sp;
  end

  assign req = sp.display_select_addr_bit & (~sp.mem_read_strobe_n | ~sp.mem_write_strobe_n);
  assign qualify = req & ~sp.refresh_pending & ~sp.video_read_active;
  assign ras_fall = prev_r.row_strobe_n & ~sp.row_strobe_n;
  assign field_rise = ~prev_r.field_rate_pulse & sp.field_rate_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // Memory access sequencer.

  vcsft_acc_t acc_r, acc_nxt;
  logic access_done;

  always_comb
  begin
    acc_nxt = acc_r;
    access_done = 1'b0;
    unique case (acc_r)
      ACC_IDLE:
      begin
        if (ras_fall && qualify)
          acc_nxt = ACC_GRANT;
      end
      ACC_GRANT:
      begin
        if (!req)
          acc_nxt = ACC_IDLE;
        else if (ras_fall)
        begin
          acc_nxt = ACC_READY;
          access_done = 1'b1;
        end
      end
      ACC_READY:
      begin
        if (!req)
          acc_nxt = ACC_IDLE;
      end
      default: acc_nxt = ACC_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      acc_r <= ACC_IDLE;
    else
      acc_r <= acc_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag latch.

  logic [7:0] flags_r, flags_nxt;

  always_comb
  begin
    flags_nxt = flags_r;
    if (!sp.flag_latch_load_n)
      flags_nxt[sp.data_low[2:0]] = sp.data_low[3];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      flags_r <= FLAGS_RST;
    else
      flags_r <= flags_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sound timers and tone gating.

  logic [CNT_W-1:0] bell_r, bell_nxt, tick_r, tick_nxt, tone_r, tone_nxt;
  logic tone_sq_r, tone_sq_nxt, bell_act, tick_act;
  logic [31:0] control_r;

  assign bell_act = (bell_r != '0);
  assign tick_act = (tick_r != '0);

  always_comb
  begin
    bell_nxt = bell_act ? bell_r - 1'b1 : bell_r;
    tick_nxt = tick_act ? tick_r - 1'b1 : tick_r;
    if (flags_nxt[FLAG_BELL] && !flags_r[FLAG_BELL])
      bell_nxt = CNT_W'(BELL_LEN);
    if (flags_nxt[FLAG_TICK] && !flags_r[FLAG_TICK])
      tick_nxt = CNT_W'(TICK_LEN);
    tone_nxt = tone_r + 1'b1;
    tone_sq_nxt = tone_sq_r;
    if (tone_r >= CNT_W'(TONE_HALF - 1))
    begin
      tone_nxt = '0;
      tone_sq_nxt = ~tone_sq_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bell_r <= '0;
      tick_r <= '0;
      tone_r <= '0;
      tone_sq_r <= 1'b0;
    end
    else
    begin
      bell_r <= bell_nxt;
      tick_r <= tick_nxt;
      tone_r <= tone_nxt;
      tone_sq_r <= tone_sq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decade counter and timer interrupt.

  logic [3:0] decade_r, decade_nxt;
  logic timer_irq_r, timer_irq_nxt, carry;

  // Ten fields at the 50 Hz field rate give the 200 ms tick.
  assign carry = field_rise & flags_r[FLAG_TIMER_EN] & (decade_r == DECADE_LAST);

  always_comb
  begin
    decade_nxt = decade_r;
    if (field_rise && flags_r[FLAG_TIMER_EN])
      decade_nxt = (decade_r == DECADE_LAST) ? DECADE_RST : decade_r + 1'b1;
    timer_irq_nxt = timer_irq_r;
    if (sp.timer_irq_clear)
      timer_irq_nxt = 1'b0;
    if (carry)
      timer_irq_nxt = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      decade_r <= DECADE_RST;
      timer_irq_r <= 1'b0;
    end
    else
    begin
      decade_r <= decade_nxt;
      timer_irq_r <= timer_irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs.

  always_comb
  begin
    outs.mem_grant = (acc_r == ACC_GRANT);
    outs.cpu_route_en = (acc_r == ACC_GRANT);
    outs.ready_n = ~(acc_r == ACC_READY);
    outs.timer_irq = timer_irq_r;
    outs.speaker_drive = tone_sq_r & (bell_act | tick_act) & control_r[CTL_SPEAKER_EN_BIT];
    outs.flag_outputs = flags_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB registers and event interrupt.

  logic [EV_WIDTH-1:0] status_r, status_nxt, mask_r, mask_nxt, events;
  logic [31:0] control_nxt, prdata_nxt;
  logic wr, rd, hit;

  assign events = {access_done, carry};
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;
  assign hit = (paddr[7:0] == REG_STATUS_OFS) | (paddr[7:0] == REG_MASK_OFS) |
               (paddr[7:0] == REG_STATE_OFS) | (paddr[7:0] == REG_CONTROL_OFS);
  assign pready = 1'b1;
  assign pslverr = psel & penable & (~hit | (paddr[31:8] != 24'h00_0000));
  assign irq = |(status_r & mask_r);

  always_comb
  begin
    status_nxt = status_r;
    mask_nxt = mask_r;
    control_nxt = control_r;
    prdata_nxt = prdata;
    if (wr && !pslverr)
    begin
      if (paddr[7:0] == REG_STATUS_OFS)
        status_nxt = status_r & ~pwdata[EV_WIDTH-1:0];
      if (paddr[7:0] == REG_MASK_OFS)
        mask_nxt = pwdata[EV_WIDTH-1:0];
      if (paddr[7:0] == REG_CONTROL_OFS)
        control_nxt = {31'h0000_0000, pwdata[CTL_SPEAKER_EN_BIT]};
    end
    status_nxt = status_nxt | events;
    if (rd)
    begin
      prdata_nxt = 32'h0000_0000;
      unique case (paddr[7:0])
        REG_STATUS_OFS: prdata_nxt = {30'h0000_0000, status_r};
        REG_MASK_OFS: prdata_nxt = {30'h0000_0000, mask_r};
        REG_STATE_OFS: prdata_nxt = {14'h0000, decade_r, tick_act, bell_act, timer_irq_r,
                                     acc_r, flags_r};
        REG_CONTROL_OFS: prdata_nxt = control_r;
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      status_r <= STATUS_RST;
      mask_r <= MASK_RST;
      control_r <= CONTROL_RST;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      control_r <= control_nxt;
      prdata <= prdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  qualify_block_a: assert property (
    (acc_r == ACC_IDLE) && (sp.refresh_pending || sp.video_read_active) |=> !outs.mem_grant)
    else $error("grant issued while memory busy");
  grant_on_ras_a: assert property (
    (acc_r == ACC_IDLE) && ras_fall && qualify |=> outs.mem_grant && outs.ready_n)
    else $error("grant missing after row strobe");
  route_in_grant_a: assert property (
    outs.cpu_route_en |-> outs.mem_grant && $past(req))
    else $error("processor routed outside grant");
  ready_after_grant_a: assert property (
    outs.mem_grant && ras_fall && req |=> !outs.mem_grant && !outs.ready_n)
    else $error("ready not set when grant dropped");
  ready_clear_a: assert property (
    !outs.ready_n && !req |=> outs.ready_n)
    else $error("ready not cleared after strobes rose");
  flag_hold_a: assert property (
    sp.flag_latch_load_n |=> $stable(outs.flag_outputs))
    else $error("flags changed without load strobe");
  flag_decode_a: assert property (
    !sp.flag_latch_load_n |=> outs.flag_outputs[$past(sp.data_low[2:0])] == $past(sp.data_low[3]))
    else $error("flag line not decoded");
  tone_block_a: assert property (
    !bell_act && !tick_act |-> !outs.speaker_drive)
    else $error("tone leaked with sound timers idle");
  count_gate_a: assert property (
    !flags_r[FLAG_TIMER_EN] |=> $stable(decade_r))
    else $error("decade counter advanced while disabled");
  irq_set_a: assert property (
    carry |=> outs.timer_irq ##1 (outs.timer_irq || $past(sp.timer_irq_clear)))
    else $error("timer interrupt not set by carry");
  irq_hold_a: assert property (
    outs.timer_irq && !sp.timer_irq_clear |=> outs.timer_irq)
    else $error("timer interrupt dropped without clear");
  reset_state_a: assert property (@(posedge clk) disable iff (1'b0)
    srst |=> outs.ready_n && !outs.mem_grant && outs.flag_outputs == 8'h00 && !outs.timer_irq)
    else $error("reset left state pending");

  grant_seen_c: cover property (outs.mem_grant ##[1:50] !outs.ready_n);
  irq_seen_c: cover property (carry ##1 outs.timer_irq);
  tone_seen_c: cover property (outs.speaker_drive);

endmodule

// *** tb/tb_top.sv ***
// Self-checking bench of the video sync, flag and timer block.
`timescale 1ns/1ps
module tb_top;
  import vcsft_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  vcsft_pins_t pv = PINS_RST;
  vcsft_pins_t pins;
  vcsft_outs_t outs;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq;
  logic start = 1'b0;
  logic wr = 1'b0;
  logic sel, rd_n, wr_n, busy;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  int rc = 0;
  int gcnt = 0;
  int tog = 0;
  int t0;
  logic pg = 1'b0;
  logic pr = 1'b1;
  logic sp = 1'b0;
  logic [7:0] fe;

  always #4 clk = ~clk;

  always_comb
  begin
    pins = pv;
    pins.display_select_addr_bit = sel;
    pins.mem_read_strobe_n = rd_n;
    pins.mem_write_strobe_n = wr_n;
  end

  vcsft_top #(.TONE_HALF(4), .BELL_LEN(200), .TICK_LEN(100)) uut (
    .clk(clk), .srst(srst), .pins(pins), .outs(outs), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));

  vcsft_cpu_model cpu (.clk(clk), .start(start), .wr(wr), .ready_n(outs.ready_n),
    .sel(sel), .rd_n(rd_n), .wr_n(wr_n), .busy(busy));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("Checks: %0d, mismatches: %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    if (pready !== 1'b1)
      mismatches++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    msk_q.push_back(m);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic flag(input logic [2:0] line, input logic v);
    pv.data_low <= {v, line};
    @(posedge clk);
    pv.flag_latch_load_n <= 1'b0;
    repeat (6) @(posedge clk);
    pv.flag_latch_load_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  task automatic fields(input int k);
    repeat (k)
    begin
      pv.field_rate_pulse <= 1'b1;
      repeat (8) @(posedge clk);
      pv.field_rate_pulse <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Row strobe source, output watchers and the run limit.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    rc <= (rc == 15) ? 0 : rc + 1;
    pv.row_strobe_n <= (rc < 10);
    pg <= outs.mem_grant;
    pr <= outs.ready_n;
    sp <= outs.speaker_drive;
    tog <= (sp !== outs.speaker_drive) ? tog + 1 : tog;
    gcnt <= (outs.mem_grant === 1'b1) ? gcnt + 1 : 0;
    check(outs.cpu_route_en, outs.mem_grant);
    if (pg === 1'b1 && outs.mem_grant === 1'b0)
      check(gcnt, 16);
    if (pr === 1'b1 && outs.ready_n === 1'b0)
      check({pg, outs.mem_grant}, 2'b10);
    if (cyc == 30000)
    begin
      mismatches = mismatches + 1;
      test_done();
    end
  end

  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1)
      check(pslverr, paddr[31:8] != 24'h0 || paddr[1:0] != 2'b0 || paddr[7:0] > REG_CONTROL_OFS);
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      check(prdata & msk_q.pop_front(), exp_q.pop_front());
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h9702));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd(REG_STATUS_OFS, '1, 32'h0);
    rd(REG_MASK_OFS, '1, 32'h0);
    rd(REG_STATE_OFS, '1, 32'h100);
    rd(REG_CONTROL_OFS, '1, CONTROL_RST);
    apb(1'b1, 32'h10, '1);
    rd(32'h10, '1, 32'h0);
    rd(REG_MASK_OFS, '1, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      pv.data_low <= 4'($urandom);
      repeat (6) @(posedge clk);
      fe[i] = 1'($urandom);
      flag(3'(i), fe[i]);
    end
    rd(REG_STATE_OFS, 32'hff, {24'h0, fe});
    check(outs.flag_outputs, fe);
    for (int i = 0; i < 8; i++)
      flag(3'(i), 1'b0);
    rd(REG_STATE_OFS, 32'hff, 32'h0);
    check(outs.flag_outputs, 8'h00);
    for (int i = 2; i < 4; i++)
    begin
      flag(3'(i), 1'b1);
      flag(3'(i), 1'b0);
      t0 = tog;
      repeat (40) @(posedge clk);
      check(tog != t0, 1'b1);
      rd(REG_STATE_OFS, 32'h3000, 32'h1000 << (i - 2));
      repeat (250) @(posedge clk);
      t0 = tog;
      repeat (40) @(posedge clk);
      check(tog == t0 && outs.speaker_drive === 1'b0, 1'b1);
    end
    apb(1'b1, REG_CONTROL_OFS, 32'h0);
    rd(REG_CONTROL_OFS, '1, 32'h0);
    flag(3'd2, 1'b1);
    t0 = tog;
    repeat (40) @(posedge clk);
    check(tog == t0 && outs.speaker_drive === 1'b0, 1'b1);
    flag(3'd2, 1'b0);
    apb(1'b1, REG_CONTROL_OFS, 32'h1);
    for (int k = 0; k < 2; k++)
    begin
      pv.refresh_pending <= (k == 0);
      pv.video_read_active <= (k == 1);
      repeat (4 + 4'($urandom)) @(posedge clk);
      wr <= k[0];
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (100) @(posedge clk);
      rd(REG_STATE_OFS, 32'h700, 32'h100);
      rd(REG_STATUS_OFS, 32'h2, 32'h0);
      pv.refresh_pending <= 1'b0;
      pv.video_read_active <= 1'b0;
      t0 = 0;
      while (busy !== 1'b0 && t0 < 500)
      begin
        @(posedge clk);
        t0++;
      end
      if (busy !== 1'b0)
        mismatches++;
      rd(REG_STATUS_OFS, 32'h2, 32'h2);
      rd(REG_STATE_OFS, 32'h700, 32'h100);
      apb(1'b1, REG_STATUS_OFS, 32'h2);
    end
    fields(10);
    rd(REG_STATE_OFS, 32'h3c800, 32'h0);
    flag(3'd1, 1'b1);
    fields(9);
    rd(REG_STATE_OFS, 32'h3c800, 32'h24000);
    fields(1);
    rd(REG_STATE_OFS, 32'h3c800, 32'h800);
    check(irq, 1'b0);
    apb(1'b1, REG_MASK_OFS, 32'h1);
    check(irq, 1'b1);
    repeat (50) @(posedge clk);
    check(outs.timer_irq, 1'b1);
    pv.timer_irq_clear <= 1'b1;
    repeat (8) @(posedge clk);
    pv.timer_irq_clear <= 1'b0;
    repeat (8) @(posedge clk);
    check(outs.timer_irq, 1'b0);
    check(irq, 1'b1);
    apb(1'b1, REG_STATUS_OFS, 32'h1);
    check(irq, 1'b0);
    rd(REG_STATUS_OFS, 32'h1, 32'h0);
    flag(3'd1, 1'b0);
    test_done();
  end
endmodule

// *** tb/vcsft_cpu_model.sv ***
// Processor bus model that requests display memory and waits for ready.
`timescale 1ns/1ps
module vcsft_cpu_model (
  input wire logic clk,
  input wire logic start,
  input wire logic wr,
  input wire logic ready_n,
  output logic sel,
  output logic rd_n,
  output logic wr_n,
  output logic busy
);
  int n;

  initial
  begin
    sel = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    busy = 1'b0;
    forever
    begin
      @(posedge clk);
      if (start)
      begin
        n = 0;
        busy <= 1'b1;
        sel <= 1'b1;
        rd_n <= wr;
        wr_n <= !wr;
        @(posedge clk);
        while (ready_n !== 1'b0 && n < 400)
        begin
          @(posedge clk);
          n++;
        end
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        sel <= 1'b0;
        repeat (8) @(posedge clk);
        busy <= 1'b0;
      end
    end
  end
endmodule
